// ---- clkgen_params.svh ----
/*
 Constants of the clock generator: register offsets, reset values, flag
 bit positions and timing counts. Definitions only; included by bare name.
*/
`ifndef CLKGEN_PARAMS_SVH
`define CLKGEN_PARAMS_SVH

// register port widths
`define ADDR_W 8
`define DATA_W 8

// register offsets (byte addresses)
`define OFS_CLK_SELECT 8'h00
`define OFS_MON_CTRL 8'h04
`define OFS_FLAGS 8'h08
`define OFS_TICK_RATE 8'h0C
`define OFS_WDOG_RATE 8'h10
`define OFS_WDOG_SERVICE 8'h14

// reset values; the monitor and self-clock enables come up set
`define CLK_SELECT_RESET 7'h00
`define MON_CTRL_RESET 3'h3
`define RATE_RESET 3'h0

// flag register bit positions
`define FLAG_SCM_FLAG 0
`define FLAG_SCM_MODE 1
`define FLAG_WAIT 2

// rate counters and clock quality check
`define RATE_W 3
`define RATE_BASE 4
`define CHECK_WINDOW 50000
`define CHECK_OK_EDGES 4096

// clock monitor silence time, longest time so the count rounds down
`define CLK_PERIOD_NS 8
`define CM_TIMEOUT_NS 2000
`define CM_TIMEOUT_CYC (`CM_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// ---- clkgen_pkg.sv ----
/*
 Types of the clock generator: clock source, wait sequence states and the
 packed carriers for configuration, clock gates and events.
 Assumes the constants header is on the include path.
*/
`include "clkgen_params.svh"

package clkgen_pkg;

   // which clock drives the system
   typedef enum logic [1:0] {SRC_OSC, SRC_PLL, SRC_SCM} system_clock_src_type;

   // wait entry sequence
   typedef enum logic [2:0] {ST_RUN, ST_CLK_SWITCH, ST_PLL_OFF, ST_CORE_OFF, ST_WAIT} wait_state_type;

   // clock select and wait configuration, bit 6 first
   typedef struct packed {
      logic osc_amplitude_reduce_in_wait;
      logic watchdog_stop_in_wait;
      logic periodic_tick_stop_in_wait;
      logic system_stop_in_wait;
      logic core_stop_in_wait;
      logic pll_stop_in_wait;
      logic pll_clock_select;
   } clksel_type;

   // clock monitor control, bit 2 first
   typedef struct packed {
      logic selfclock_irq_enable;
      logic self_clock_mode_enable;
      logic clock_monitor_enable;
   } mon_ctrl_type;

   // clock and power enables
   typedef struct packed {
      logic voltage_regulator_on;
      logic osc_reduce;
      logic sys_en;
      logic core_en;
      logic pll_on;
   } gate_type;

   // one-cycle event pulses
   typedef struct packed {
      logic clock_fail_reset;
      logic watchdog_reset;
      logic selfclock_irq;
      logic tick_irq;
      logic wake;
   } event_type;

endpackage

// ---- clkgen_rate_counter.sv ----
/*
 Rate-selected timeout counter used for the periodic tick and the watchdog.
 Counts step pulses (oscillator edges); period is 2^(BASE+rate-1) steps.
 Assumes step, run and restart are synchronous to clk.
*/
`timescale 1ns/1ps
`include "clkgen_params.svh"

module clkgen_rate_counter #(
   parameter int RATE_W = `RATE_W,
   parameter int BASE = `RATE_BASE
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic [RATE_W-1:0] rate,
   input wire logic run,
   input wire logic step,
   input wire logic restart,
   // timeout pulse
   output logic expire_q
);
   localparam int CNT_W = BASE + (1 << RATE_W) - 2;
   localparam logic [RATE_W-1:0] MAXR = '1;

   if (RATE_W < 1 || RATE_W > 4 || BASE < 1) begin : g_bad
      $error("clkgen_rate_counter: unsupported RATE_W or BASE");
   end

   logic [CNT_W-1:0] cnt_q, cnt_d, limit;
   logic expire_d;

   // rate zero holds the counter cleared, which is how software stops it
   always_comb begin
      limit = {CNT_W{1'b1}} >> (MAXR - rate);
      cnt_d = cnt_q;
      expire_d = 1'b0;
      if (restart || rate == '0) begin  // see RL7 see RL8
         cnt_d = '0;
      end else if (run && step) begin  // see RL9
         if (cnt_q == limit) begin
            cnt_d = '0;
            expire_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= '0;
         expire_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         expire_q <= expire_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   property p_stopped_quiet;
      (rate == '0) |=> !expire_q;
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet) else $error("stopped counter expired"); // see RL7

   c_expire: cover property (expire_q);
endmodule

// ---- clkgen_quality_check.sv ----
/*
 Clock quality checker: counts minimum-frequency VCO ticks in windows and
 oscillator edges inside each window; enough edges ends the window at once.
 Assumes vco_tick and osc_edge are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps
`include "clkgen_params.svh"

module clkgen_quality_check #(
   parameter int WINDOW = `CHECK_WINDOW,
   parameter int OK_EDGES = `CHECK_OK_EDGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // check request and sampled clocks
   input wire logic run,
   input wire logic vco_tick,
   input wire logic osc_edge,
   // result pulse
   output logic osc_ok_q
);
   localparam int WIN_W = $clog2(WINDOW + 1);
   localparam int EDGE_W = $clog2(OK_EDGES + 1);

   if (OK_EDGES < 1 || WINDOW <= OK_EDGES) begin : g_bad
      $error("clkgen_quality_check: window must exceed the edge count");
   end

   logic [WIN_W-1:0] win_q, win_d;
   logic [EDGE_W-1:0] edge_q, edge_d;
   logic ok_d;

   // windows repeat for as long as run is held, so a failed check retries
   always_comb begin
      win_d = win_q + WIN_W'(vco_tick);
      edge_d = edge_q + EDGE_W'(osc_edge);
      ok_d = 1'b0;
      if (!run) begin
         win_d = '0;
         edge_d = '0;
      end else if (edge_d == EDGE_W'(OK_EDGES)) begin  // see RL22
         ok_d = 1'b1;
         win_d = '0;
         edge_d = '0;
      end else if (win_d == WIN_W'(WINDOW)) begin  // see RL21
         win_d = '0;
         edge_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         win_q <= '0;
         edge_q <= '0;
         osc_ok_q <= 1'b0;
      end else begin
         win_q <= win_d;
         edge_q <= edge_d;
         osc_ok_q <= ok_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   property p_ok_edges;
      osc_ok_q |-> $past(run) && $past(osc_edge) && ($past(edge_q) == EDGE_W'(OK_EDGES - 1));
   endproperty
   a_ok_edges: assert property (p_ok_edges) else $error("ok without enough edges"); // see RL22

   property p_window_bound;
      win_q < WIN_W'(WINDOW);
   endproperty
   a_window_bound: assert property (p_window_bound) else $error("check window overran"); // see RL22
endmodule

// ---- clkgen_top.sv ----
/*
 Clock and reset generator control: clock monitor, self-clock mode,
 wait mode entry and wake-up, periodic tick and watchdog rates, and a
 small register file on a plain read/write port.
 Assumes one 125 MHz clock, a synchronous active-high reset, and that the
 oscillator and minimum-frequency VCO arrive as one-cycle edge pulses.
*/
// Decided for this implementation: the register addresses and the plain strobed port.
// How it works
// RL1: monitor enabled, self-clock enabled, clock missing: run from minimum-frequency VCO.
// RL2: entering self-clock mode clears pll_clock_select.
// RL3: good oscillator again switches back to osc_clock and leaves self-clock mode.
// RL4: monitor off on pll_clock: loss undetected, clock drifts, returns later.
// RL5: monitor off on osc_clock: loss leaves the system static, no recovery.
// RL6: software keeps clock_monitor_enable set at all times.
// RL7: periodic tick rate zero stops the tick counter.
// RL8: watchdog rate zero stops the watchdog counter.
// RL9: wait bits act independently on PLL, core, system, tick, watchdog, oscillator; here system_stop_in_wait also stops the core.
// RL10: wait request: clear pll select, PLL off, core off, system off.
// RL11: wait ends on reset, clock fail, watchdog, self-clock or tick interrupt.
// RL12: external reset returns every configuration bit to its default.
// RL13: clock fail without self-clock enable issues clock_fail_reset at once.
// RL14: clock fail with interrupt enabled sets flag, interrupts, wakes in self-clock.
// RL15: clock fail with interrupt masked sets flag, self-clock, checks, no wake.
// RL16: other interrupt wakes at once; stopped PLL leaves osc_clock selected.
// RL17: wait from self-clock keeps checking with PLL and regulator on.
// RL18: monitor off: clock failure in wait causes no action.
// RL19: recovery in wait ends self-clock mode, PLL per wait bit, stays waiting.
// RL20: wake after recovery runs on osc_clock.
// RL21: no recovery: checks repeat forever, wake leaves in self-clock mode.
// RL22: check window 50000 VCO cycles; 4096 oscillator edges mean good.
// RL23: oscillator silent too long means clock monitor failure.
// RL24: selfclock_flag stays set until software clears it.
`timescale 1ns/1ps
`include "clkgen_params.svh"

module clkgen_top
   import clkgen_pkg::*;
#(
   parameter int CHECK_WINDOW = `CHECK_WINDOW,
   parameter int CHECK_OK_EDGES = `CHECK_OK_EDGES,
   parameter int CM_TIMEOUT = `CM_TIMEOUT_CYC,
   parameter int RATE_BASE = `RATE_BASE
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // register port
   input wire logic [`ADDR_W-1:0] ADDR,
   input wire logic [`DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [`DATA_W-1:0] RDATA,
   // core and clock sources
   input wire logic WAIT_REQ,
   input wire logic OTHER_WAKE,
   input wire logic OSC_EDGE,
   input wire logic VCO_TICK,
   // clock control results
   output system_clock_src_type SYSTEM_CLOCK_SRC,
   output gate_type GATES,
   output event_type EVENTS
);
   localparam int DW = `DATA_W;
   localparam int AW = `ADDR_W;
   localparam int CM_W = $clog2(CM_TIMEOUT + 1);

   if (CM_TIMEOUT < 1 || CHECK_WINDOW <= CHECK_OK_EDGES || DW < $bits(clksel_type)) begin : g_bad
      $error("clkgen_top: unsupported monitor, check or data width settings");
   end

   // register address match, shared by all write strobes
   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
      return a == ofs;
   endfunction

   clksel_type clksel_q, clksel_d;
   mon_ctrl_type mon_q, mon_d;
   logic flag_q, flag_d;
   logic [`RATE_W-1:0] tick_rate_q, tick_rate_d;
   logic [`RATE_W-1:0] wdog_rate_q, wdog_rate_d;
   logic [CM_W-1:0] silence_q, silence_d;
   logic fail_seen_q, fail_seen_d;
   logic scm_q, scm_d;
   wait_state_type state_q, state_d;
   system_clock_src_type src_d;
   gate_type gates_d;
   event_type events_d;
   logic [DW-1:0] rdata_d;
   logic fail_lvl, cm_evt, scm_evt, cf_evt, irq_evt;
   logic wake, in_wait, tick_exp, wdog_exp, chk_ok;
   logic wr_clksel, wr_mon, wr_flags, wr_tick, wr_wdog, wr_service;

   // write strobes per register
   assign wr_clksel = WR && hit(ADDR, `OFS_CLK_SELECT);
   assign wr_mon = WR && hit(ADDR, `OFS_MON_CTRL);
   assign wr_flags = WR && hit(ADDR, `OFS_FLAGS);
   assign wr_tick = WR && hit(ADDR, `OFS_TICK_RATE);
   assign wr_wdog = WR && hit(ADDR, `OFS_WDOG_RATE);
   assign wr_service = WR && hit(ADDR, `OFS_WDOG_SERVICE);

   // wake sources; the tick and watchdog are already gated by their wait bits
   assign in_wait = (state_q == ST_WAIT);
   assign wake = tick_exp || wdog_exp || irq_evt || cf_evt || OTHER_WAKE;  // see RL11 see RL16

   // clock monitor: count cycles since the last oscillator edge
   always_comb begin
      silence_d = silence_q;
      if (OSC_EDGE) begin
         silence_d = '0;
      end else if (silence_q != CM_W'(CM_TIMEOUT)) begin
         silence_d = silence_q + 1'b1;
      end
      // with the monitor off no loss is seen, whatever the source
      fail_lvl = mon_q.clock_monitor_enable && (silence_q == CM_W'(CM_TIMEOUT));  // see RL23 see RL18 see RL4 see RL5
      fail_seen_d = fail_lvl;
      cm_evt = fail_lvl && !fail_seen_q;
      scm_evt = cm_evt && mon_q.self_clock_mode_enable;  // see RL1
      cf_evt = cm_evt && !mon_q.self_clock_mode_enable;  // see RL13
      irq_evt = scm_evt && mon_q.selfclock_irq_enable;  // see RL14
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         silence_q <= '0;
         fail_seen_q <= 1'b0;
      end else begin
         silence_q <= silence_d;
         fail_seen_q <= fail_seen_d;
      end
   end

   // self-clock mode holds until a quality check passes, in run or in wait
   always_comb begin
      scm_d = scm_q;
      if (scm_evt) begin
         scm_d = 1'b1;  // see RL1 see RL15
      end else if (chk_ok) begin
         scm_d = 1'b0;  // see RL3 see RL19
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         scm_q <= 1'b0;
      end else begin
         scm_q <= scm_d;
      end
   end

   // software registers; hardware clears of pll_clock_select beat a write
   always_comb begin
      clksel_d = clksel_q;
      mon_d = mon_q;
      tick_rate_d = tick_rate_q;
      wdog_rate_d = wdog_rate_q;
      flag_d = flag_q;
      if (wr_clksel) begin
         clksel_d = clksel_type'(WDATA[$bits(clksel_type)-1:0]);
      end
      if (wr_mon) begin
         mon_d = mon_ctrl_type'(WDATA[$bits(mon_ctrl_type)-1:0]);
      end
      if (wr_tick) begin
         tick_rate_d = WDATA[`RATE_W-1:0];
      end
      if (wr_wdog) begin
         wdog_rate_d = WDATA[`RATE_W-1:0];
      end
      if (scm_evt) begin
         clksel_d.pll_clock_select = 1'b0;  // see RL2
      end
      if (state_q == ST_CLK_SWITCH && clksel_q.pll_stop_in_wait) begin
         clksel_d.pll_clock_select = 1'b0;  // see RL10 see RL16
      end
      if (wr_flags && WDATA[`FLAG_SCM_FLAG]) begin
         flag_d = 1'b0;
      end
      if (scm_evt) begin
         flag_d = 1'b1;  // see RL24 see RL14 see RL15
      end
   end

   // external reset puts every configuration bit back to its default
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin  // see RL12
         clksel_q <= clksel_type'(`CLK_SELECT_RESET);
         mon_q <= mon_ctrl_type'(`MON_CTRL_RESET);
         tick_rate_q <= `RATE_RESET;
         wdog_rate_q <= `RATE_RESET;
         flag_q <= 1'b0;
      end else begin
         clksel_q <= clksel_d;
         mon_q <= mon_d;
         tick_rate_q <= tick_rate_d;
         wdog_rate_q <= wdog_rate_d;
         flag_q <= flag_d;
      end
   end

   // wait entry: switch clock, stop PLL, stop core, stop system; any wake aborts
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: begin
            if (WAIT_REQ && !wake) begin
               state_d = ST_CLK_SWITCH;  // see RL10
            end
         end
         ST_CLK_SWITCH: state_d = ST_PLL_OFF;
         ST_PLL_OFF: state_d = ST_CORE_OFF;
         ST_CORE_OFF: state_d = ST_WAIT;
         ST_WAIT: state_d = ST_WAIT;
      endcase
      if (state_q != ST_RUN && wake) begin
         state_d = ST_RUN;  // see RL11 see RL20
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // periodic tick, stepped by oscillator edges
   clkgen_rate_counter #(.RATE_W(`RATE_W), .BASE(RATE_BASE)) u_tick (
      .clk(SYS_CLK),
      .reset(RESET),
      .rate(tick_rate_q),  // see RL7
      .run(!(in_wait && clksel_q.periodic_tick_stop_in_wait)),  // see RL9
      .step(OSC_EDGE),
      .restart(wr_tick),
      .expire_q(tick_exp)
   );

   // watchdog; any write to its rate or service register restarts it
   clkgen_rate_counter #(.RATE_W(`RATE_W), .BASE(RATE_BASE)) u_wdog (
      .clk(SYS_CLK),
      .reset(RESET),
      .rate(wdog_rate_q),  // see RL8
      .run(!(in_wait && clksel_q.watchdog_stop_in_wait)),  // see RL9
      .step(OSC_EDGE),
      .restart(wr_wdog || wr_service),
      .expire_q(wdog_exp)
   );

   // quality checks run for the whole of self-clock mode, also in wait
   clkgen_quality_check #(.WINDOW(CHECK_WINDOW), .OK_EDGES(CHECK_OK_EDGES)) u_check (
      .clk(SYS_CLK),
      .reset(RESET),
      .run(scm_q),  // see RL17 see RL21
      .vco_tick(VCO_TICK),
      .osc_edge(OSC_EDGE),
      .osc_ok_q(chk_ok)
   );

   // outputs are registered, so they trail the state by one cycle
   always_comb begin
      src_d = SRC_OSC;
      if (scm_q) begin
         src_d = SRC_SCM;  // see RL1 see RL21
      end else if (clksel_q.pll_clock_select) begin
         src_d = SRC_PLL;  // see RL4
      end
      // the PLL never stops while selected or while self-clocked
      gates_d.pll_on = scm_q || clksel_q.pll_clock_select
                       || !((state_q inside {ST_PLL_OFF, ST_CORE_OFF, ST_WAIT}) && clksel_q.pll_stop_in_wait);  // see RL9 see RL19
      gates_d.core_en = !((state_q inside {ST_CORE_OFF, ST_WAIT})
                          && (clksel_q.core_stop_in_wait || clksel_q.system_stop_in_wait));  // see RL9 see RL10
      gates_d.sys_en = !(in_wait && clksel_q.system_stop_in_wait);  // see RL10
      gates_d.osc_reduce = in_wait && clksel_q.osc_amplitude_reduce_in_wait;  // see RL9
      gates_d.voltage_regulator_on = 1'b1;  // see RL17 see RL19
      events_d.clock_fail_reset = cf_evt;  // see RL13
      events_d.watchdog_reset = wdog_exp;
      events_d.selfclock_irq = irq_evt;  // see RL14
      events_d.tick_irq = tick_exp;
      events_d.wake = wake && state_q != ST_RUN;  // see RL11
      rdata_d = '0;
      if (RD) begin
         case (ADDR)
            `OFS_CLK_SELECT: rdata_d = DW'(clksel_q);
            `OFS_MON_CTRL: rdata_d = DW'(mon_q);
            `OFS_FLAGS: begin
               rdata_d[`FLAG_SCM_FLAG] = flag_q;
               rdata_d[`FLAG_SCM_MODE] = scm_q;
               rdata_d[`FLAG_WAIT] = in_wait;
            end
            `OFS_TICK_RATE: rdata_d = DW'(tick_rate_q);
            `OFS_WDOG_RATE: rdata_d = DW'(wdog_rate_q);
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         SYSTEM_CLOCK_SRC <= SRC_OSC;
         GATES <= '1;
         EVENTS <= '0;
         RDATA <= '0;
      end else begin
         SYSTEM_CLOCK_SRC <= src_d;
         GATES <= gates_d;
         EVENTS <= events_d;
         RDATA <= rdata_d;
      end
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   property p_scm_entry;
      scm_evt |=> scm_q ##1 (SYSTEM_CLOCK_SRC == SRC_SCM);
   endproperty
   a_scm_entry: assert property (p_scm_entry) else $error("self-clock entry missed"); // see RL1

   property p_pll_sel_clear;
      scm_evt |=> !clksel_q.pll_clock_select;
   endproperty
   a_pll_sel_clear: assert property (p_pll_sel_clear) else $error("pll select kept on self-clock entry"); // see RL2

   property p_scm_exit;
      (scm_q && chk_ok && !scm_evt) |=> !scm_q ##1 (SYSTEM_CLOCK_SRC != SRC_SCM);
   endproperty
   a_scm_exit: assert property (p_scm_exit) else $error("self-clock not left after good check"); // see RL3

   property p_cf_reset;
      (cm_evt && !mon_q.self_clock_mode_enable) |=> EVENTS.clock_fail_reset && !scm_q ##1 !scm_q;
   endproperty
   a_cf_reset: assert property (p_cf_reset) else $error("clock fail reset missing"); // see RL13

   property p_irq_wake;
      (scm_evt && mon_q.selfclock_irq_enable && state_q != ST_RUN) |=> EVENTS.selfclock_irq && EVENTS.wake
         && state_q == ST_RUN;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("self-clock interrupt did not wake"); // see RL14

   property p_masked_no_irq;
      (scm_evt && !mon_q.selfclock_irq_enable) |=> !EVENTS.selfclock_irq && flag_q && scm_q;
   endproperty
   a_masked_no_irq: assert property (p_masked_no_irq) else $error("masked self-clock event misbehaved"); // see RL15

   property p_monitor_off;
      (!mon_q.clock_monitor_enable && !scm_q) |=> !scm_q && !EVENTS.clock_fail_reset;
   endproperty
   a_monitor_off: assert property (p_monitor_off) else $error("action with monitor off"); // see RL18

   property p_sys_off_in_wait;
      !GATES.sys_en |-> $past(state_q) == ST_WAIT && $past(clksel_q.system_stop_in_wait);
   endproperty
   a_sys_off_in_wait: assert property (p_sys_off_in_wait) else $error("system clock off outside wait"); // see RL10

   property p_flag_sticky;
      (flag_q && !(wr_flags && WDATA[`FLAG_SCM_FLAG])) |=> flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without clear"); // see RL24

   property p_wake_exit;
      (state_q != ST_RUN && wake) |=> state_q == ST_RUN && EVENTS.wake;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("wake did not end wait"); // see RL11

   c_masked_fail_in_wait: cover property (in_wait && scm_evt && !mon_q.selfclock_irq_enable);
   c_recovery_in_wait: cover property (in_wait && scm_q && chk_ok);
   c_cf_reset: cover property (cf_evt);
endmodule

// ---- osc_model.sv ----
/*
 Oscillator and minimum-frequency VCO model facing the clock generator.
 Assumes one system clock; both outputs are one-cycle pulses on it.
*/
`timescale 1ns/1ps
module osc_model (
   // clock and control
   input wire logic clk,
   input wire logic run,
   input wire logic [2:0] period,
   // clock pulses
   output logic osc_edge,
   output logic vco_tick
);
   logic [2:0] cnt_q = 3'h0;
   initial osc_edge = 1'b0;
   initial vco_tick = 1'b0;
   // a stopped crystal gives no edges at all; the vco never stops
   always @(posedge clk) begin
      cnt_q <= (cnt_q >= period) ? 3'h0 : cnt_q + 3'h1;
      osc_edge <= run && (cnt_q == 3'h0);
      vco_tick <= ~vco_tick;
   end
endmodule

// ---- tb_clkgen_top.sv ----
/*
 Self-checking bench for the clock generator top.
 Assumes the package, the design files and the oscillator model come first.
*/
`timescale 1ns/1ps
`include "clkgen_params.svh"
module tb_clkgen_top;
   import clkgen_pkg::*;
   logic SYS_CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, WAIT_REQ = 1'b0, OTHER_WAKE = 1'b0;
   logic run = 1'b1, wd_any = 1'b0, clear = 1'b0, OSC_EDGE, VCO_TICK;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
   logic [2:0] period = 3'h1;
   system_clock_src_type SYSTEM_CLOCK_SRC;
   gate_type GATES;
   event_type EVENTS, seen = '0;
   int fail_count = 0, comparisons = 0;
   // clock
   always #4 SYS_CLK = ~SYS_CLK;
   osc_model i_osc (.clk(SYS_CLK), .run(run), .period(period), .osc_edge(OSC_EDGE), .vco_tick(VCO_TICK));
   // short counts keep the run brief
   clkgen_top #(.CHECK_WINDOW(100), .CHECK_OK_EDGES(8), .CM_TIMEOUT(16), .RATE_BASE(1)) i_dut (
      .SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .WAIT_REQ(WAIT_REQ), .OTHER_WAKE(OTHER_WAKE), .OSC_EDGE(OSC_EDGE), .VCO_TICK(VCO_TICK),
      .SYSTEM_CLOCK_SRC(SYSTEM_CLOCK_SRC), .GATES(GATES), .EVENTS(EVENTS));
   // pulses are one cycle long, so keep a sticky record of them
   always @(posedge SYS_CLK) begin
      seen <= clear ? '0 : seen | EVENTS;
      wd_any <= wd_any | EVENTS.watchdog_reset;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 d = RDATA;
      chk(d, exp);
   endtask
   task automatic pulse(input bit w);
      @(posedge SYS_CLK);
      if (w) WAIT_REQ <= 1'b1;
      else OTHER_WAKE <= 1'b1;
      @(posedge SYS_CLK);
      WAIT_REQ <= 1'b0;
      OTHER_WAKE <= 1'b0;
      cyc(8);
   endtask
   task automatic osc(input logic on, input int n);
      @(posedge SYS_CLK);
      run <= on;
      cyc(n);
   endtask
   // the record is cleared by its own process, one edge after the request
   task automatic clr();
      clear <= 1'b1;
      @(posedge SYS_CLK);
      clear <= 1'b0;
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // hang guard, far beyond the few thousand cycles the tests need
   initial begin
      #400000;
      fail_count++;
      results();
   end
   initial begin
      void'($urandom(32'h5ABCF5A0));
      cyc(3);
      RESET <= 1'b0;
      rd(`OFS_CLK_SELECT, 8'h00);
      rd(`OFS_MON_CTRL, 8'h03);
      rd(8'h18, 8'h00);
      rd(`OFS_WDOG_SERVICE, 8'h00);
      // random register traffic at a random oscillator pace
      repeat (8) begin
         d = 8'($urandom);
         period <= 3'($urandom_range(3, 1));
         wr(`OFS_CLK_SELECT, d);
         rd(`OFS_CLK_SELECT, d & 8'h7F);
         wr(`OFS_MON_CTRL, d);
         rd(`OFS_MON_CTRL, d & 8'h07);
      end
      wr(`OFS_MON_CTRL, 8'h03);
      // loss while on the pll, then automatic return
      wr(`OFS_CLK_SELECT, 8'h01);
      osc(0, 30);
      chk(8'(SYSTEM_CLOCK_SRC), 8'(SRC_SCM));
      rd(`OFS_CLK_SELECT, 8'h00);
      osc(1, 500);
      chk(8'(SYSTEM_CLOCK_SRC), 8'(SRC_OSC));
      rd(`OFS_FLAGS, 8'h01);
      wr(`OFS_FLAGS, 8'h01);
      // wait entry with PLL, core and system clocks stopped, woken by another source
      wr(`OFS_CLK_SELECT, 8'h4F);
      clr();
      pulse(1);
      chk(8'(GATES), 8'h18);
      rd(`OFS_FLAGS, 8'h04);
      pulse(0);
      chk(8'(seen.wake), 8'h01);
      rd(`OFS_CLK_SELECT, 8'h4E);
      // masked loss in wait: no wake, checks run, recovery stays in wait
      wr(`OFS_CLK_SELECT, 8'h02);
      pulse(1);
      osc(0, 30);
      rd(`OFS_FLAGS, 8'h07);
      chk(8'(GATES.pll_on), 8'h01);
      osc(1, 500);
      rd(`OFS_FLAGS, 8'h05);
      chk(8'(GATES.pll_on), 8'h00);
      pulse(0);
      chk(8'(SYSTEM_CLOCK_SRC), 8'(SRC_OSC));
      wr(`OFS_FLAGS, 8'h01);
      // unmasked loss in wait wakes into self-clock
      wr(`OFS_MON_CTRL, 8'h07);
      pulse(1);
      clr();
      osc(0, 30);
      chk(8'(seen.selfclock_irq), 8'h01);
      rd(`OFS_FLAGS, 8'h03);
      chk(8'(SYSTEM_CLOCK_SRC), 8'(SRC_SCM));
      osc(1, 500);
      // loss without self-clock asks for a reset; the reset restores defaults
      wr(`OFS_MON_CTRL, 8'h01);
      pulse(1);
      clr();
      osc(0, 30);
      chk(8'(seen.clock_fail_reset), 8'h01);
      osc(1, 20);
      RESET <= 1'b1;
      cyc(3);
      RESET <= 1'b0;
      rd(`OFS_FLAGS, 8'h00);
      // monitor off: a loss goes unseen
      wr(`OFS_MON_CTRL, 8'h00);
      clr();
      osc(0, 60);
      chk(8'(seen), 8'h00);
      chk(8'(SYSTEM_CLOCK_SRC), 8'(SRC_OSC));
      osc(1, 20);
      wr(`OFS_MON_CTRL, 8'h03);
      // tick stopped by rate zero, then by its wait bit, then wakes
      clr();
      cyc(40);
      chk(8'(seen.tick_irq), 8'h00);
      wr(`OFS_TICK_RATE, 8'h01);
      cyc(20);
      chk(8'(seen.tick_irq), 8'h01);
      wr(`OFS_CLK_SELECT, 8'h10);
      // a long period keeps a tick from aborting wait entry; the fast rate goes in once waiting
      wr(`OFS_TICK_RATE, 8'h07);
      pulse(1);
      wr(`OFS_TICK_RATE, 8'h01);
      cyc(40);
      rd(`OFS_FLAGS, 8'h04);
      wr(`OFS_CLK_SELECT, 8'h00);
      cyc(20);
      rd(`OFS_FLAGS, 8'h00);
      chk(8'(wd_any), 8'h00);
      wr(`OFS_WDOG_RATE, 8'h01);
      cyc(20);
      chk(8'(wd_any), 8'h01);
      results();
   end
endmodule
